//--- verilog/scpi_parser_pkg.sv
// constants and types of the command message parser
// assumes one system clock; characters arrive from a receiver in the same domain
package scpi_parser_pkg;

  // -----------------------------------------------------------------
  // character codes
  // -----------------------------------------------------------------
  localparam logic [7:0] CH_NL = 8'h0a;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_QMARK = 8'h3f;
  localparam logic [7:0] CH_UA = 8'h41;
  localparam logic [7:0] CH_UZ = 8'h5a;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7a;
  localparam logic [7:0] CH_D0 = 8'h30;
  localparam logic [7:0] CH_D9 = 8'h39;
  localparam logic [7:0] CASE_BIT = 8'h20;

  // -----------------------------------------------------------------
  // keyword table
  // -----------------------------------------------------------------
  localparam int KW_MAX = 12;
  localparam int NUM_KW = 12;
  localparam int SHORT_MAX = 4;
  localparam int DEPTH_MAX = 3;
  localparam logic [3:0] KW_SYST = 4'h0;
  localparam logic [3:0] KW_COMM = 4'h1;
  localparam logic [3:0] KW_SER = 4'h2;
  localparam logic [3:0] KW_BAUD = 4'h3;
  localparam logic [KW_MAX*8-1:0] KW_TEXT [NUM_KW] = '{
    "SYSTEM", "COMMUNICATE", "SERIAL", "BAUD", "VOLTAGE", "CURRENT",
    "MEASURE", "OUTPUT", "STATUS", "LEVEL", "TRIGGER", "IMMEDIATE"};
  localparam int KW_LEN [NUM_KW] = '{6, 11, 6, 4, 7, 7, 7, 6, 6, 5, 7, 9};

  // -----------------------------------------------------------------
  // serial rate settings: 2400, 4800, 9600, 19200
  // -----------------------------------------------------------------
  localparam int NUM_BAUD = 4;
  localparam logic [15:0] BAUD_RATE [NUM_BAUD] = '{16'h0960, 16'h12c0, 16'h2580, 16'h4b00};
  localparam logic [1:0] BAUD_RST = 2'h2;
  localparam logic [15:0] VAL_LIMIT = 16'h1998;
  localparam logic [15:0] VAL_SAT = 16'hffff;
  localparam logic [15:0] DEC_BASE = 16'h000a;

  typedef enum logic [1:0] {ST_KEY, ST_QUERY, ST_PARAM, ST_SKIP} pstate_e;

  typedef struct packed {
    logic query;
    logic hasPar;
    logic numeric;
    logic [15:0] value;
  } cmd_s;

  typedef struct packed {
    pstate_e fsm;
    logic [KW_MAX-1:0][7:0] kbuf;
    logic [3:0] klen;
    logic [1:0] level;
    logic [1:0] lastLvl;
    logic [3:0] lastKw;
    logic [DEPTH_MAX:0][3:0] path;
    logic unitStart;
    cmd_s cmd;
    logic pendEnd;
    logic rdy;
    logic kwStb;
    logic [3:0] kwId;
    logic [1:0] kwDepth;
    logic parStb;
    logic [7:0] parChar;
    logic cmdStb;
    cmd_s cmdOut;
    logic msgEnd;
    logic synErr;
    logic [1:0] baudSel;
  } parser_s;

endpackage

//--- verilog/scpi_message_parser.sv
// command message parser: splits a character stream into keywords and parameters
// assumes characters come from logic on clk_sys with a valid/ready handshake
`timescale 1ns/1ps
`default_nettype none

module scpi_message_parser
  import scpi_parser_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rstn, // synchronous reset, low active
  input wire logic ce, // clock enable
  input wire logic rxValid, // character offered
  input wire logic [7:0] rxChar, // character code
  input wire logic rxEol, // end-of-line flag with the character
  output logic rxReady, // character can be taken
  output logic kwStb, // keyword decoded pulse
  output logic [3:0] kwId, // keyword table index
  output logic [1:0] kwDepth, // tree level of that keyword
  output logic parStb, // parameter character pulse
  output logic [7:0] parChar, // parameter character
  output logic cmdStb, // unit complete pulse
  output cmd_s cmdInfo, // query, parameter and value of the unit
  output logic msgEnd, // message terminated pulse
  output logic synErr, // syntax error pulse
  output logic [1:0] baudSel // selected serial rate index
);

  // -----------------------------------------------------------------
  // keyword matching
  // -----------------------------------------------------------------
  function automatic logic kw_match(input int e, input logic [KW_MAX-1:0][7:0] b, input logic [3:0] n);
    logic ok;
    int l;
    int s;
    l = KW_LEN[e];
    s = l;
    if (l > SHORT_MAX) begin
      case (KW_TEXT[e][(l-SHORT_MAX)*8 +: 8])
        "A", "E", "I", "O", "U": s = SHORT_MAX - 1;
        default: s = SHORT_MAX;
      endcase
    end
    ok = (n == 4'(l)) || (n == 4'(s));
    for (int i = 0; i < KW_MAX; i++) begin
      if (i < int'(n) && i < l && b[i] != KW_TEXT[e][(l-1-i)*8 +: 8]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  parser_s st;
  parser_s nx;
  logic [NUM_KW-1:0] kwHit;
  logic anyHit;
  logic [3:0] hitId;
  logic take;
  logic act;
  logic [7:0] ch;
  logic [7:0] up;
  logic isLetter;
  logic isDigit;
  logic isDelim;
  logic doEnd;
  logic err;

  for (genvar e = 0; e < NUM_KW; e++) begin : g_kw
    assign kwHit[e] = kw_match(e, st.kbuf, st.klen);
  end

  always_comb begin
    hitId = '0;
    for (int e = 0; e < NUM_KW; e++) begin
      if (kwHit[e]) begin
        hitId = 4'(e);
      end
    end
  end

  assign anyHit = |kwHit;
  assign take = rxValid && st.rdy;
  assign act = take || st.pendEnd;
  assign ch = st.pendEnd ? CH_NL : rxChar;
  assign up = (ch >= CH_LA && ch <= CH_LZ) ? (ch ^ CASE_BIT) : ch;
  assign isLetter = up >= CH_UA && up <= CH_UZ;
  assign isDigit = ch >= CH_D0 && ch <= CH_D9;
  assign isDelim = ch == CH_COLON || ch == CH_SPACE || ch == CH_QMARK || ch == CH_SEMI || ch == CH_NL;

  // -----------------------------------------------------------------
  // parser state machine
  // -----------------------------------------------------------------
  always_comb begin
    nx = st;
    doEnd = 1'b0;
    err = 1'b0;
    nx.kwStb = 1'b0;
    nx.parStb = 1'b0;
    nx.cmdStb = 1'b0;
    nx.msgEnd = 1'b0;
    nx.synErr = 1'b0;
    if (act) begin
      case (st.fsm)
        ST_KEY: begin
          if (isLetter) begin
            if (st.klen == 4'(KW_MAX)) begin
              err = 1'b1;
            end else begin
              nx.kbuf[st.klen] = up;
              nx.klen = st.klen + 4'h1;
            end
          end else if (!isDelim) begin
            err = 1'b1;
          end else if (st.klen == '0) begin
            if (ch == CH_COLON && st.unitStart) begin
              nx.level = '0;
            end else if (!((ch == CH_SEMI || ch == CH_NL) && st.unitStart)) begin
              err = 1'b1;
            end
          end else if (!anyHit) begin
            err = 1'b1;
          end else begin
            nx.kwStb = 1'b1;
            nx.kwId = hitId;
            nx.kwDepth = st.level;
            nx.path[st.level] = hitId;
            nx.lastKw = hitId;
            nx.lastLvl = st.level;
            nx.unitStart = 1'b0;
            nx.klen = '0;
            case (ch)
              CH_COLON: begin
                if (st.level == 2'(DEPTH_MAX)) begin
                  err = 1'b1;
                end else begin
                  nx.level = st.level + 2'h1;
                end
              end
              CH_SPACE: nx.fsm = ST_PARAM;
              CH_QMARK: begin
                nx.cmd.query = 1'b1;
                nx.fsm = ST_QUERY;
              end
              default: doEnd = 1'b1;
            endcase
          end
        end
        ST_QUERY: begin
          if (ch == CH_SPACE) begin
            nx.fsm = ST_PARAM;
          end else if (ch == CH_SEMI || ch == CH_NL) begin
            doEnd = 1'b1;
          end else begin
            err = 1'b1;
          end
        end
        ST_PARAM: begin
          if (ch == CH_SEMI || ch == CH_NL) begin
            doEnd = 1'b1;
          end else begin
            nx.parStb = 1'b1;
            nx.parChar = ch;
            nx.cmd.hasPar = 1'b1;
            nx.cmd.numeric = isDigit && (st.cmd.numeric || !st.cmd.hasPar);
            if (!st.cmd.hasPar) begin
              nx.cmd.value = {12'h000, ch[3:0]};
            end else if (st.cmd.value > VAL_LIMIT) begin
              nx.cmd.value = VAL_SAT;
            end else begin
              nx.cmd.value = 16'(st.cmd.value * DEC_BASE + {12'h000, ch[3:0]});
            end
          end
        end
        ST_SKIP: begin
          nx.fsm = ST_SKIP;
        end
        default: nx.fsm = ST_KEY;
      endcase

      if (doEnd) begin
        nx.cmdStb = 1'b1;
        nx.cmdOut = nx.cmd;
        if (nx.lastKw == KW_BAUD && nx.lastLvl == 2'(DEPTH_MAX) && nx.path[0] == KW_SYST &&
            nx.path[1] == KW_COMM && nx.path[2] == KW_SER && !nx.cmd.query) begin
          err = 1'b1;
          for (int b = 0; b < NUM_BAUD; b++) begin
            if (nx.cmd.hasPar && nx.cmd.numeric && nx.cmd.value == BAUD_RATE[b]) begin
              nx.baudSel = 2'(b);
              err = 1'b0;
            end
          end
        end
        nx.cmd = '0;
        nx.unitStart = 1'b1;
        nx.fsm = ST_KEY;
      end

      if (err) begin
        nx.synErr = 1'b1;
        nx.klen = '0;
        nx.cmd = '0;
        nx.fsm = ST_SKIP;
      end

      if (ch == CH_NL) begin
        nx.msgEnd = 1'b1;
        nx.level = '0;
        nx.klen = '0;
        nx.cmd = '0;
        nx.unitStart = 1'b1;
        nx.fsm = ST_KEY;
      end

      nx.pendEnd = take && rxEol && rxChar != CH_NL;
      nx.rdy = !nx.pendEnd;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st <= '0;
      st.rdy <= 1'b1;
      st.unitStart <= 1'b1;
      st.baudSel <= BAUD_RST;
    end else if (ce) begin
      st <= nx;
    end
  end

  assign rxReady = st.rdy;
  assign kwStb = st.kwStb;
  assign kwId = st.kwId;
  assign kwDepth = st.kwDepth;
  assign parStb = st.parStb;
  assign parChar = st.parChar;
  assign cmdStb = st.cmdStb;
  assign cmdInfo = st.cmdOut;
  assign msgEnd = st.msgEnd;
  assign synErr = st.synErr;
  assign baudSel = st.baudSel;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_eolEnds;
    @(posedge clk_sys) disable iff (!rstn)
    (take && rxEol && rxChar != CH_NL && ce) ##1 ce |=> msgEnd;
  endproperty
  a_eolEnds: assert property (p_eolEnds) else $error("eol char did not end message");

  property p_nlEnds;
    @(posedge clk_sys) disable iff (!rstn)
    take && rxChar == CH_NL && ce |=> msgEnd && st.level == '0 && st.fsm == ST_KEY;
  endproperty
  a_nlEnds: assert property (p_nlEnds) else $error("newline did not return to root");

  property p_unitDone;
    @(posedge clk_sys) disable iff (!rstn)
    take && !st.pendEnd && rxChar == CH_NL && st.fsm == ST_KEY && st.klen != '0 && anyHit && ce
      |=> kwStb && cmdStb && msgEnd;
  endproperty
  a_unitDone: assert property (p_unitDone) else $error("keyword unit not completed");

  property p_badForm;
    @(posedge clk_sys) disable iff (!rstn)
    act && st.fsm == ST_KEY && isDelim && st.klen != '0 && !anyHit && ce |=> synErr && !kwStb;
  endproperty
  a_badForm: assert property (p_badForm) else $error("bad abbreviation accepted");

  property p_caseFold;
    @(posedge clk_sys) disable iff (!rstn)
    take && !st.pendEnd && st.fsm == ST_KEY && rxChar >= CH_LA && rxChar <= CH_LZ &&
      st.klen < 4'(KW_MAX) && ce |=> st.kbuf[$past(st.klen)] == ($past(rxChar) ^ CASE_BIT);
  endproperty
  a_caseFold: assert property (p_caseFold) else $error("letter not folded to upper case");

  property p_descend;
    @(posedge clk_sys) disable iff (!rstn)
    act && st.fsm == ST_KEY && ch == CH_COLON && st.klen != '0 && anyHit && st.level != 2'(DEPTH_MAX) && ce
      |=> kwStb && st.level == $past(st.level) + 2'h1;
  endproperty
  a_descend: assert property (p_descend) else $error("colon did not descend a level");

  property p_semiSplit;
    @(posedge clk_sys) disable iff (!rstn)
    take && st.fsm == ST_PARAM && rxChar == CH_SEMI && ce |=> cmdStb && !msgEnd;
  endproperty
  a_semiSplit: assert property (p_semiSplit) else $error("semicolon did not close unit");

  property p_query;
    @(posedge clk_sys) disable iff (!rstn)
    act && st.fsm == ST_KEY && ch == CH_QMARK && st.klen != '0 && anyHit && ce
      |=> st.fsm == ST_QUERY && st.cmd.query;
  endproperty
  a_query: assert property (p_query) else $error("query marker not recorded");

  property p_errSkip;
    @(posedge clk_sys) disable iff (!rstn)
    synErr && !msgEnd |-> st.fsm == ST_SKIP && st.cmd == '0 && st.klen == '0;
  endproperty
  a_errSkip: assert property (p_errSkip) else $error("error did not skip to terminator");

  property p_baudOnCmd;
    @(posedge clk_sys) disable iff (!rstn)
    $changed(baudSel) |-> cmdStb && cmdInfo.numeric && cmdInfo.value == BAUD_RATE[baudSel];
  endproperty
  a_baudOnCmd: assert property (p_baudOnCmd) else $error("rate changed without valid command");

  property p_param;
    @(posedge clk_sys) disable iff (!rstn)
    act && st.fsm == ST_KEY && ch == CH_SPACE && st.klen != '0 && anyHit && ce |=> st.fsm == ST_PARAM;
  endproperty
  a_param: assert property (p_param) else $error("space did not open parameter");

  property p_resetRoot;
    @(posedge clk_sys)
    $rose(rstn) |-> st.level == '0 && st.klen == '0 && !synErr && rxReady && st.fsm == ST_KEY;
  endproperty
  a_resetRoot: assert property (p_resetRoot) else $error("parser not at root after reset");

endmodule
`default_nettype wire

//--- tb/ctrl_model.sv
// remote controller model: sends queued ASCII characters to the parser
// assumes the parser takes a character on a rising edge with rxValid, rxReady and ce high
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
  import scpi_parser_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic ce, // clock enable seen by the parser
  input wire logic rxReady, // parser can take a character
  output logic rxValid, // character offered
  output logic [7:0] rxChar, // character code
  output logic rxEol // end-of-line flag
);
  logic [8:0] q[$];
  logic [8:0] cur;

  initial begin
    rxValid = 1'b0;
    rxChar = 8'h00;
    rxEol = 1'b0;
  end

  // -----------------------------------------------------------------
  // message queue
  // -----------------------------------------------------------------
  // every character of the string, end-of-line flag on the last one when eolLast
  task automatic send(input string s, input bit eolLast);
    for (int i = 0; i < s.len(); i++) begin
      q.push_back({eolLast && (i == s.len() - 1), s[i]});
    end
  endtask

  // -----------------------------------------------------------------
  // character driver
  // -----------------------------------------------------------------
  // hold each character until taken
  always @(posedge clk_sys) begin
    if (!rxValid || (rxReady && ce)) begin
      if (q.size() > 0) begin
        cur = q.pop_front();
        rxValid <= 1'b1;
        rxChar <= cur[7:0];
        rxEol <= cur[8];
      end else begin
        rxValid <= 1'b0;
        rxEol <= 1'b0;
        rxChar <= ~rxChar;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// testbench of the command message parser
// assumes the controller model drives the character input; one 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import scpi_parser_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic rxValid, rxEol, rxReady, kwStb, parStb, cmdStb, msgEnd, synErr;
  logic [7:0] rxChar, parChar;
  logic [3:0] kwId;
  logic [1:0] kwDepth, baudSel;
  cmd_s cmdInfo, cmdLast;
  logic [3:0] kwLast;
  logic [1:0] dLast;
  int kwCnt, cmdCnt, endCnt, errCnt, parCnt;
  int failures = 0;
  int checks = 0;
  logic [15:0] rates [4] = '{16'h0960, 16'h12c0, 16'h2580, 16'h4b00};

  always #25 clk_sys = ~clk_sys;

  ctrl_model model (.clk_sys(clk_sys), .ce(ce), .rxReady(rxReady), .rxValid(rxValid), .rxChar(rxChar),
    .rxEol(rxEol));

  scpi_message_parser dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .rxValid(rxValid), .rxChar(rxChar),
    .rxEol(rxEol), .rxReady(rxReady), .kwStb(kwStb), .kwId(kwId), .kwDepth(kwDepth), .parStb(parStb),
    .parChar(parChar), .cmdStb(cmdStb), .cmdInfo(cmdInfo), .msgEnd(msgEnd), .synErr(synErr),
    .baudSel(baudSel));

  // -----------------------------------------------------------------
  // event monitor
  // -----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (kwStb === 1'b1) begin
      kwCnt++;
      kwLast = kwId;
      dLast = kwDepth;
    end
    if (cmdStb === 1'b1) begin
      cmdCnt++;
      cmdLast = cmdInfo;
    end
    if (msgEnd === 1'b1) endCnt++;
    if (synErr === 1'b1) errCnt++;
    if (parStb === 1'b1) parCnt++;
  end

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic run(input string s, input bit eol);
    int n;
    kwCnt = 0;
    cmdCnt = 0;
    endCnt = 0;
    errCnt = 0;
    parCnt = 0;
    model.send(s, eol);
    n = 0;
    @(posedge clk_sys);
    while ((rxValid === 1'b1 || model.q.size() > 0) && n < 500) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (4) @(posedge clk_sys);
    check("drain", n < 500, 1'b1);
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    check("rxReady", rxReady, 1'b1);
    check("baudSel", baudSel, 2'h2);
    check("cmdInfo", cmdInfo, 19'h0_0000);
    check("kwDepth", kwDepth, 2'h0);
    check("synErr", synErr, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_baud();
    string s;
    for (int i = 0; i < 4; i++) begin
      if (i % 2) begin
        s = "SyStEm:communicate:SERIAL:baud";
      end else begin
        s = "syst:COMM:ser:BAUD";
      end
      run($sformatf("%s %0d\n", s, rates[i]), 1'b0);
      check("baudSel", baudSel, i);
      check("cmdInfo", cmdLast, {1'b0, 1'b1, 1'b1, rates[i]});
      check("kwCnt", kwCnt, 4);
      check("kwDepth", dLast, 2'h3);
      check("kwId", kwLast, 4'h3);
      check("msgEnd", endCnt, 1);
      check("synErr", errCnt, 0);
    end
    run("SYST:COMM:SER:BAUD 1234\n", 1'b0);
    check("badRate err", errCnt, 1);
    check("badRate sel", baudSel, 2'h3);
    $display("test baud done");
  endtask

  task automatic t_forms();
    string f [8] = '{"VOLT?", "voltage?", "cUrReNt?", "OUTP?", "stat?", "VOLT:LEV:IMM?",
      "volt:level:immediate?", "trigger?"};
    logic [3:0] id [8] = '{4'h4, 4'h4, 4'h5, 4'h7, 4'h8, 4'hb, 4'hb, 4'ha};
    for (int i = 0; i < 8; i++) begin
      run({f[i], "\n"}, 1'b0);
      check(f[i], kwLast, id[i]);
      check("depth", dLast, (i == 5 || i == 6) ? 2'h2 : 2'h0);
      check("query", {cmdLast.query, cmdLast.hasPar}, 2'b10);
      check("cmdCnt", cmdCnt, 1);
      check("synErr", errCnt, 0);
    end
    $display("test forms done");
  endtask

  task automatic t_bad();
    string f [5] = '{"VOLTA:LEV\n", "VOLT:LEV:IMME\n", "VOLT:LEVE\n", "CURRE?\n", "VOL;VOLT?\n"};
    for (int i = 0; i < 5; i++) begin
      run(f[i], 1'b0);
      check("synErr", errCnt, 1);
      check("cmdCnt", cmdCnt, 0);
      check("msgEnd", endCnt, 1);
    end
    run("VOLT?\n", 1'b0);
    check("resume", cmdCnt, 1);
    $display("test bad done");
  endtask

  task automatic t_units();
    run("VOLT 15;:CURR?\n", 1'b0);
    check("cmdCnt", cmdCnt, 2);
    check("kwId", kwLast, 4'h5);
    check("depth", dLast, 2'h0);
    check("parCnt", parCnt, 2);
    check("msgEnd", endCnt, 1);
    run("VOLT 15\n", 1'b0);
    check("num", cmdLast, {1'b0, 1'b1, 1'b1, 16'h000f});
    run("OUTP ON\n", 1'b0);
    check("str", {cmdLast.hasPar, cmdLast.numeric}, 2'b10);
    check("parChar", parChar, 8'h4e);
    $display("test units done");
  endtask

  task automatic t_end();
    run("TRIG", 1'b1);
    check("eol end", endCnt, 1);
    check("eol cmd", cmdCnt, 1);
    check("eol kw", kwLast, 4'ha);
    run("VOLT?", 1'b0);
    check("no end", endCnt, 0);
    check("no cmd", cmdCnt, 0);
    run("\n", 1'b0);
    check("nl end", endCnt, 1);
    check("nl cmd", cmdCnt, 1);
    $display("test end done");
  endtask

  // parser must hold all state while ce is low, then finish the unit
  task automatic t_ce();
    kwCnt = 0;
    cmdCnt = 0;
    endCnt = 0;
    ce <= 1'b0;
    model.send("CURR?\n", 1'b0);
    repeat (6) @(posedge clk_sys);
    check("ce freeze", kwCnt + cmdCnt + endCnt, 0);
    check("ce ready", rxReady, 1'b1);
    ce <= 1'b1;
    repeat (12) @(posedge clk_sys);
    check("ce kw", kwLast, 4'h5);
    check("ce cmd", cmdCnt, 1);
    check("ce end", endCnt, 1);
    check("ce query", cmdLast.query, 1'b1);
    $display("test ce done");
  endtask

  // -----------------------------------------------------------------
  // main sequence and watchdog
  // -----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_baud();
    t_forms();
    t_bad();
    t_units();
    t_end();
    t_ce();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
